/* File: vim_mapper.sv */
/*
 * Vectored interrupt mapper: 32 vector slots, two base pointers, one
 * pending flag / enable register pair, priority choice toward the core.
 * Assumes request inputs are single-cycle or level events on clk, except
 * the external lines and the wakeup pin, which come from pins.
 */
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "vim_defines.svh"

module vim_mapper (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ext_request_a,
  input  wire logic        ext_request_b,
  input  wire logic        wakeup_pin,
  input  wire logic        timer_aggregate_event,
  input  wire logic        uart_event,
  input  wire logic        dma_event,
  input  wire logic        display_event,
  input  wire logic        converter_done,
  input  wire logic        converter_pin_event,
  input  wire logic        audio2_receive_event,
  input  wire logic        audio2_transmit_event,
  input  wire logic        audio0_tx_event,
  input  wire logic        audio0_rx_event,
  input  wire logic        card0_event,
  input  wire logic        card0_io_event,
  input  wire logic        audio1_tx_event,
  input  wire logic        audio1_rx_event,
  input  wire logic        card1_event,
  input  wire logic        card1_io_event,
  input  wire logic        clock_event,
  input  wire logic        os_event,
  input  wire logic        soft_reset,
  input  wire logic        core_ack,
  output logic             core_req,
  output logic [4:0]       core_slot,
  output logic [4:0]       core_prio,
  output logic [31:0]      core_vector,
  output logic             irq,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ****************************************************************
  // Fixed slot priorities
  // ****************************************************************
  localparam logic [4:0] PRIO [0:31] = '{
    5'd0,  5'd1,  5'd3,  5'd5,  5'd6,  5'd7,  5'd9,  5'd10,
    5'd11, 5'd13, 5'd14, 5'd15, 5'd17, 5'd18, 5'd21, 5'd22,
    5'd4,  5'd8,  5'd12, 5'd16, 5'd19, 5'd20, 5'd23, 5'd24,
    5'd2,  5'd25, 5'd26, 5'd14, 5'd15, 5'd16, 5'd17, 5'd18};

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= {wakeup_pin, ext_request_b, ext_request_a};
      pin_s2_r <= pin_s1_r;
    end
  end

  vim_pkg::vim_state_t s_r;
  vim_pkg::vim_state_t s_nxt;

  // ****************************************************************
  // Request sources
  // ****************************************************************
  logic [15:0] src;
  logic        nmi_line;
  logic        clock_slot_req;
  logic        sh0_tx;
  logic        sh0_rx;
  logic        sh1_tx;
  logic        sh1_rx;
  logic [31:0] slot_req;
  logic [4:0]  best_slot;
  logic [4:0]  best_prio;
  logic        best_valid;
  logic        wr_fire;
  logic [31:0] rd_val;
  logic        rd_ok;

  assign nmi_line = 1'b0;
  assign clock_slot_req = pin_s2_r[2] | clock_event;

  // Shared sources per port mode; other mode codes raise nothing
  always_comb begin
    sh0_tx = (s_r.mode0 == `VIM_MODE_CARD)  ? card0_event :
             (s_r.mode0 == `VIM_MODE_AUDIO) ? audio0_tx_event : 1'b0;
    sh0_rx = (s_r.mode0 == `VIM_MODE_CARD)  ? card0_io_event :
             (s_r.mode0 == `VIM_MODE_AUDIO) ? audio0_rx_event : 1'b0;
    sh1_tx = (s_r.mode1 == `VIM_MODE_CARD)  ? card1_event :
             (s_r.mode1 == `VIM_MODE_AUDIO) ? audio1_tx_event : 1'b0;
    sh1_rx = (s_r.mode1 == `VIM_MODE_CARD)  ? card1_io_event :
             (s_r.mode1 == `VIM_MODE_AUDIO) ? audio1_rx_event : 1'b0;
  end

  always_comb begin
    src = 16'h0000;
    src[`VIM_BIT_EXT_A]   = pin_s2_r[0];
    src[`VIM_BIT_EXT_B]   = pin_s2_r[1];
    src[`VIM_BIT_TIMER]   = timer_aggregate_event;
    src[`VIM_BIT_SH0_TX]  = sh0_tx;
    src[`VIM_BIT_UART]    = uart_event;
    src[`VIM_BIT_SH0_RX]  = sh0_rx;
    src[`VIM_BIT_DMA]     = dma_event;
    src[`VIM_BIT_SH1_TX]  = sh1_tx;
    src[`VIM_BIT_SH1_RX]  = sh1_rx;
    src[`VIM_BIT_DISPLAY] = display_event;
    src[`VIM_BIT_CONV]    = converter_done | converter_pin_event;
    src[`VIM_BIT_AUD2_TX] = audio2_transmit_event;
    src[`VIM_BIT_AUD2_RX] = audio2_receive_event;
  end

  // ****************************************************************
  // Slot requests and priority choice
  // ****************************************************************
  logic [15:0] live;
  assign live = s_r.flags & s_r.enables;

  always_comb begin
    slot_req = s_r.swtrap;
    slot_req[1] = s_r.swtrap[1] | nmi_line;
    for (int i = 2; i < 16; i++) begin
      slot_req[i] = s_r.swtrap[i] | live[i];
    end
    slot_req[18] = s_r.swtrap[18] | clock_slot_req;
    slot_req[26] = s_r.swtrap[26] | os_event;
  end

  always_comb begin
    best_valid = 1'b0;
    best_slot  = 5'h00;
    best_prio  = `VIM_NO_PRIO;
    for (int i = 0; i <= `VIM_SLOT_LAST; i++) begin
      if (slot_req[i] && (!best_valid || PRIO[i] < best_prio)) begin
        best_valid = 1'b1;
        best_slot  = 5'(i);
        best_prio  = PRIO[i];
      end
    end
  end

  // Vector address: base chosen by slot, plus stride times slot
  function automatic logic [31:0] vim_vec(input logic [4:0] slot,
                                          input logic [31:0] pb,
                                          input logic [31:0] sb);
    logic [31:0] base;
    base = (slot >= 5'(`VIM_SEC_FIRST) && slot <= 5'(`VIM_SEC_LAST)) ? sb : pb;
    return base + 32'({slot, 3'b000});
  endfunction

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      `VIM_OFF_FLAGS:   rd_val = {16'h0000, s_r.flags};
      `VIM_OFF_ENABLES: rd_val = {16'h0000, s_r.enables};
      `VIM_OFF_PBASE:   rd_val = s_r.pbase;
      `VIM_OFF_SBASE:   rd_val = s_r.sbase;
      `VIM_OFF_MODE:    rd_val = {28'h000_0000, s_r.mode1, s_r.mode0};
      `VIM_OFF_SWTRAP:  rd_val = s_r.swtrap;
      `VIM_OFF_STATUS:  rd_val = {21'h00_0000, s_r.req_valid, s_r.req_prio, s_r.req_slot};
      default:          rd_ok = 1'b0;
    endcase
  end

  assign s_axi_awready = (s_r.wst == vim_pkg::VIM_AXI_IDLE) && !s_r.aw_seen;
  assign s_axi_wready  = (s_r.wst == vim_pkg::VIM_AXI_IDLE) && !s_r.w_seen;
  assign s_axi_arready = (s_r.rst_st == vim_pkg::VIM_AXI_IDLE);
  assign s_axi_bvalid  = (s_r.wst == vim_pkg::VIM_AXI_WRESP);
  assign s_axi_rvalid  = (s_r.rst_st == vim_pkg::VIM_AXI_RRESP);
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = s_r.rdata;
  assign core_req      = s_r.req_valid;
  assign core_slot     = s_r.req_slot;
  assign core_prio     = s_r.req_prio;
  assign core_vector   = s_r.req_vector;
  assign irq           = |live;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [31:0] d;
    logic [15:0] clr;
    logic        ok;
    s_nxt   = s_r;
    d       = 32'h0000_0000;
    clr     = 16'h0000;
    ok      = 1'b1;
    wr_fire = 1'b0;

    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_seen = 1'b1;
      s_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_seen = 1'b1;
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
    end

    case (s_r.wst)
      vim_pkg::VIM_AXI_IDLE: begin
        if (s_r.aw_seen && s_r.w_seen) begin
          wr_fire = 1'b1;
          s_nxt.aw_seen = 1'b0;
          s_nxt.w_seen  = 1'b0;
          s_nxt.wst     = vim_pkg::VIM_AXI_WRESP;
        end
      end
      vim_pkg::VIM_AXI_WRESP: begin
        if (s_axi_bready) begin
          s_nxt.wst = vim_pkg::VIM_AXI_IDLE;
        end
      end
      default: s_nxt.wst = vim_pkg::VIM_AXI_IDLE;
    endcase

    if (wr_fire) begin
      for (int b = 0; b < 4; b++) begin
        d[b*8 +: 8] = s_r.wstrb[b] ? s_r.wdata[b*8 +: 8] : 8'h00;
      end
      case (s_r.awaddr)
        `VIM_OFF_FLAGS:   clr = d[15:0] & `VIM_WR_MASK;
        `VIM_OFF_ENABLES: begin
          for (int b = 0; b < 2; b++) begin
            if (s_r.wstrb[b]) begin
              s_nxt.enables[b*8 +: 8] = d[b*8 +: 8] & 8'(`VIM_WR_MASK >> (b*8));
            end
          end
        end
        `VIM_OFF_PBASE: begin
          for (int b = 0; b < 4; b++) begin
            if (s_r.wstrb[b]) s_nxt.pbase[b*8 +: 8] = d[b*8 +: 8];
          end
        end
        `VIM_OFF_SBASE: begin
          for (int b = 0; b < 4; b++) begin
            if (s_r.wstrb[b]) s_nxt.sbase[b*8 +: 8] = d[b*8 +: 8];
          end
        end
        `VIM_OFF_MODE: begin
          if (s_r.wstrb[0]) begin
            s_nxt.mode0 = d[1:0];
            s_nxt.mode1 = d[3:2];
          end
        end
        `VIM_OFF_SWTRAP: s_nxt.swtrap = s_r.swtrap | d;
        `VIM_OFF_STATUS: ok = 1'b0;
        default:         ok = 1'b0;
      endcase
      s_nxt.bresp = ok ? 2'b00 : 2'b10;
    end

    // Set wins over a clear in the same cycle
    s_nxt.flags = ((s_r.flags & ~clr) | src) & `VIM_WR_MASK;

    case (s_r.rst_st)
      vim_pkg::VIM_AXI_IDLE: begin
        if (s_axi_arvalid) begin
          s_nxt.rdata  = rd_val;
          s_nxt.rresp  = rd_ok ? 2'b00 : 2'b10;
          s_nxt.rst_st = vim_pkg::VIM_AXI_RRESP;
        end
      end
      vim_pkg::VIM_AXI_RRESP: begin
        if (s_axi_rready) begin
          s_nxt.rst_st = vim_pkg::VIM_AXI_IDLE;
        end
      end
      default: s_nxt.rst_st = vim_pkg::VIM_AXI_IDLE;
    endcase

    // Offer to the core: held until acknowledged, then cleared at source; a pending reset offer displaces it unacknowledged
    if (s_r.reset_pend) begin
      s_nxt.req_valid  = 1'b1;
      s_nxt.req_slot   = `VIM_RESET_SLOT;
      s_nxt.req_prio   = `VIM_RESET_PRIO;
      s_nxt.req_vector = vim_vec(`VIM_RESET_SLOT, s_r.pbase, s_r.sbase);
      if (s_r.req_valid && core_ack) begin
        s_nxt.reset_pend = 1'b0;
        s_nxt.req_valid  = 1'b0;
      end
    end else if (s_r.req_valid) begin
      if (core_ack) begin
        s_nxt.req_valid = 1'b0;
        if (s_r.req_slot < 5'd16) begin
          s_nxt.flags[s_r.req_slot[3:0]] = src[s_r.req_slot[3:0]];
        end
        s_nxt.swtrap[s_r.req_slot] = 1'b0;
      end
    end else if (best_valid) begin
      s_nxt.req_valid  = 1'b1;
      s_nxt.req_slot   = best_slot;
      s_nxt.req_prio   = best_prio;
      s_nxt.req_vector = vim_vec(best_slot, s_r.pbase, s_r.sbase);
    end
    if (soft_reset) s_nxt.reset_pend = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r            <= '0;
      s_r.flags      <= `VIM_FLAGS_RST;
      s_r.enables    <= `VIM_ENABLES_RST;
      s_r.pbase      <= `VIM_PBASE_RST;
      s_r.sbase      <= `VIM_SBASE_RST;
      s_r.wst        <= vim_pkg::VIM_AXI_IDLE;
      s_r.rst_st     <= vim_pkg::VIM_AXI_IDLE;
      s_r.reset_pend <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

/* File: vim_defines.svh */
/*
 * Constants for the vectored interrupt mapper: register offsets, field
 * positions, reset values and slot table figures.
 * Assumes inclusion by bare name from the mapper's package and module.
 */
`ifndef VIM_DEFINES_SVH
`define VIM_DEFINES_SVH

// ****************************************************************
// Register byte offsets on the AXI4-Lite slave
// ****************************************************************
`define VIM_OFF_FLAGS     12'h000
`define VIM_OFF_ENABLES   12'h004
`define VIM_OFF_PBASE     12'h008
`define VIM_OFF_SBASE     12'h00C
`define VIM_OFF_MODE      12'h010
`define VIM_OFF_SWTRAP    12'h014
`define VIM_OFF_STATUS    12'h018

// ****************************************************************
// Flag and enable layout
// ****************************************************************
`define VIM_BIT_EXT_A     2
`define VIM_BIT_EXT_B     3
`define VIM_BIT_TIMER     4
`define VIM_BIT_SH0_TX    5
`define VIM_BIT_UART      6
`define VIM_BIT_SH0_RX    7
`define VIM_BIT_DMA       8
`define VIM_BIT_SH1_TX    9
`define VIM_BIT_SH1_RX    11
`define VIM_BIT_DISPLAY   12
`define VIM_BIT_CONV      13
`define VIM_BIT_AUD2_TX   14
`define VIM_BIT_AUD2_RX   15
`define VIM_WR_MASK       16'hF_BFC
`define VIM_FLAGS_RST     16'h0000
`define VIM_ENABLES_RST   16'h0000
`define VIM_PBASE_RST     32'h0000_0000
`define VIM_SBASE_RST     32'h0000_0000

// ****************************************************************
// Slot table
// ****************************************************************
`define VIM_SLOT_STRIDE   8
`define VIM_SLOT_LAST     31
`define VIM_SEC_FIRST     16
`define VIM_SEC_LAST      23
`define VIM_MODE_CARD     2'b00
`define VIM_MODE_AUDIO    2'b01
`define VIM_NO_PRIO       5'h1F
`define VIM_RESET_SLOT    5'h00
`define VIM_RESET_PRIO    5'h00

`endif

/* File: vim_pkg.sv */
/*
 * Types for the vectored interrupt mapper.
 * Assumes the defines header is compiled alongside.
 */
`include "vim_defines.svh"

package vim_pkg;
  typedef enum logic [1:0] {VIM_AXI_IDLE, VIM_AXI_WRESP, VIM_AXI_RRESP} vim_axi_st_t;

  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] enables;
    logic [31:0] pbase;
    logic [31:0] sbase;
    logic [1:0]  mode0;
    logic [1:0]  mode1;
    logic [31:0] swtrap;
    logic        aw_seen;
    logic        w_seen;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    vim_axi_st_t wst;
    vim_axi_st_t rst_st;
    logic        req_valid;
    logic [4:0]  req_slot;
    logic [4:0]  req_prio;
    logic [31:0] req_vector;
    logic        reset_pend;
  } vim_state_t;
endpackage

/* File: vim_mapper_props.sv */
/* Checker for the mapper's core link and AXI4-Lite answers.
   Assumes it is bound onto vim_mapper and sees only its ports. */
`timescale 1ns/1ps
module vim_mapper_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        core_ack,
  input wire logic        core_req,
  input wire logic [4:0]  core_slot,
  input wire logic [4:0]  core_prio,
  input wire logic [31:0] core_vector,
  input wire logic        irq,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // ****************
  // Fixed slot priorities
  // ****************
  localparam logic [4:0] PRIO [32] = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h06, 5'h07, 5'h09,
    5'h0A, 5'h0B, 5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h12, 5'h15, 5'h16, 5'h04, 5'h08, 5'h0C,
    5'h10, 5'h13, 5'h14, 5'h17, 5'h18, 5'h02, 5'h19, 5'h1A, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12};
  default clocking cb @(posedge clk); endclocking

  a_slot_prio: assert property (disable iff (rst) core_req |-> core_prio == PRIO[core_slot])
    else $error("priority does not match slot");
  a_req_hold: assert property (disable iff (rst) core_req && !core_ack |=>
    core_req && $stable(core_slot) && $stable(core_vector)) else $error("request moved");
  a_req_drop: assert property (disable iff (rst) core_req && core_ack |=> !core_req)
    else $error("request kept after ack");
  a_reset_offer: assert property (disable iff (rst) $fell(rst) |->
    ##[0:2] (core_req && core_slot == 5'h00 && core_prio == 5'h00))
    else $error("no reset request after reset");
  a_rst_quiet: assert property (rst |=> !core_req && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active during reset");
  a_bresp_hold: assert property (disable iff (rst) s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (disable iff (rst) s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_lat: assert property (disable iff (rst) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

bind vim_mapper vim_mapper_props u_props (.clk(clk), .rst(rst), .core_ack(core_ack),
  .core_req(core_req), .core_slot(core_slot), .core_prio(core_prio),
  .core_vector(core_vector), .irq(irq), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata));

/* File: vim_core_model.sv */
/* Core model: takes offered requests a few cycles late while allowed.
   Assumes the mapper holds a request until it is acknowledged. */
`timescale 1ns/1ps
module vim_core_model #(parameter int WAIT = 2) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       core_req,
  input  wire logic [4:0] core_slot,
  input  wire logic       ack_en,
  output logic            core_ack,
  output logic [7:0]      taken,
  output logic [4:0]      last_slot
);
  // ****************
  // Slow acknowledge
  // ****************
  logic [3:0] cnt_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      core_ack <= 1'b0;
      cnt_r    <= 4'h0;
      taken    <= 8'h00;
    end else if (core_ack) begin
      core_ack  <= 1'b0;
      cnt_r     <= 4'h0;
      taken     <= taken + 8'h01;
      last_slot <= core_slot;
    end else if (core_req && ack_en) begin
      if (cnt_r == 4'(WAIT)) core_ack <= 1'b1;
      else cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

/* File: vim_mapper_test.sv */
/* Self-checking bench for vim_mapper: AXI4-Lite tasks, event pulses.
   Assumes the defines header and the core model are compiled first. */
`timescale 1ns/1ps
`include "vim_defines.svh"
module vim_mapper_test;
  localparam logic [4:0] PRIO [32] = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h06, 5'h07, 5'h09,
    5'h0A, 5'h0B, 5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h12, 5'h15, 5'h16, 5'h04, 5'h08, 5'h0C,
    5'h10, 5'h13, 5'h14, 5'h17, 5'h18, 5'h02, 5'h19, 5'h1A, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12};
  localparam int TRAPS [7] = '{1, 16, 18, 23, 24, 26, 31};
  logic        clk, rst, core_ack, core_req, irq, ack_en;
  logic [4:0]  core_slot, core_prio, last_slot;
  logic [31:0] core_vector, s_axi_wdata, s_axi_rdata, pb, sb;
  logic [15:0] hw, alt;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  taken;
  int          miscompares, samples_checked, cycles, n;

  vim_mapper dut (.clk, .rst, .ext_request_a(hw[2]), .ext_request_b(hw[3]),
    .wakeup_pin(alt[0]), .timer_aggregate_event(hw[4]), .uart_event(hw[6]),
    .dma_event(hw[8]), .display_event(hw[12]), .converter_done(hw[13]),
    .converter_pin_event(alt[13]), .audio2_receive_event(hw[15]),
    .audio2_transmit_event(hw[14]), .audio0_tx_event(alt[5]), .audio0_rx_event(alt[7]),
    .card0_event(hw[5]), .card0_io_event(hw[7]), .audio1_tx_event(alt[9]),
    .audio1_rx_event(alt[11]), .card1_event(hw[9]), .card1_io_event(hw[11]),
    .clock_event(alt[1]), .os_event(alt[2]), .soft_reset(hw[0]), .core_ack, .core_req,
    .core_slot, .core_prio, .core_vector, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  vim_core_model #(.WAIT(2)) u_core (.clk, .rst, .core_req, .core_slot, .ack_en,
    .core_ack, .taken, .last_slot);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    b_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b_ok) begin
      @(negedge clk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok  = s_axi_wvalid && s_axi_wready;
      b_ok  = s_axi_bvalid === 1'b1;
      r     = s_axi_bresp;
      @(posedge clk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic a_ok, ok;
    ok = 1'b0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!ok) begin
      @(negedge clk);
      a_ok = s_axi_arvalid && s_axi_arready;
      ok   = s_axi_rvalid === 1'b1;
      d    = s_axi_rdata;
      r    = s_axi_rresp;
      @(posedge clk);
      if (a_ok) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    wr(a, d, r);
    chk(48'(r), 48'(e));
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(48'({r, d}), 48'({er, e}));
  endtask
  task automatic pulse(input int b, input logic use_alt);
    @(posedge clk);
    if (use_alt) alt[b] <= 1'b1;
    else hw[b] <= 1'b1;
    repeat (4) @(posedge clk);
    alt <= 16'h0000;
    hw  <= 16'h0000;
    repeat (4) @(posedge clk);
  endtask
  task automatic wait_take(input int t);
    while (taken != 8'(t)) @(posedge clk);
  endtask
  task automatic expect_req(input int s);
    logic [31:0] v;
    v = ((s >= 16 && s <= 23) ? sb : pb) + 32'(s * 8);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(48'({core_req, 5'(s), PRIO[s], v}), 48'({1'b1, core_slot, core_prio, core_vector}));
    n = taken;
    @(posedge clk);
    ack_en <= 1'b1;
    wait_take(n + 1);
    ack_en <= 1'b0;
  endtask
  task automatic one_bit(input int b, input logic use_alt);
    pulse(b, use_alt);
    rchk(`VIM_OFF_FLAGS, 32'h1 << b, 2'b00);
    wchk(`VIM_OFF_FLAGS, 32'h0000_FBFC ^ (32'h1 << b), 2'b00);
    rchk(`VIM_OFF_FLAGS, 32'h1 << b, 2'b00);
    chk(48'(irq), 48'h0000_0000_0000);
    wchk(`VIM_OFF_ENABLES, 32'h1 << b, 2'b00);
    @(negedge clk);
    chk(48'(irq), 48'h0000_0000_0001);
    expect_req(b);
    wchk(`VIM_OFF_ENABLES, 32'h0000_0000, 2'b00);
  endtask
  task automatic end_of_test();
    $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    rst = 1'b1;
    ack_en = 1'b0;
    hw = 16'h0000;
    alt = 16'h0000;
    pb = 32'h0000_0000;
    sb = 32'h0000_0000;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    expect_req(0);
    rchk(`VIM_OFF_FLAGS, 32'h0000_0000, 2'b00);
    rchk(`VIM_OFF_ENABLES, 32'h0000_0000, 2'b00);
    wchk(`VIM_OFF_ENABLES, 32'h0000_FBFC, 2'b00);
    rchk(`VIM_OFF_ENABLES, 32'h0000_FBFC, 2'b00);
    wchk(`VIM_OFF_ENABLES, 32'h0000_0000, 2'b00);
    rchk(12'h100, 32'h0000_0000, 2'b10);
    wchk(12'h100, 32'h0000_0001, 2'b10);
    pb = 32'h1000_0000;
    sb = 32'h2000_0000;
    wchk(`VIM_OFF_PBASE, pb, 2'b00);
    wchk(`VIM_OFF_SBASE, sb, 2'b00);
    rchk(`VIM_OFF_SBASE, sb, 2'b00);
    pulse(4, 1'b0);
    wchk(`VIM_OFF_FLAGS, 32'h0000_0010, 2'b00);
    rchk(`VIM_OFF_FLAGS, 32'h0000_0000, 2'b00);
    for (int b = 2; b < 16; b++) if (b != 10) one_bit(b, 1'b0);
    wchk(`VIM_OFF_MODE, 32'h0000_0005, 2'b00);
    pulse(5, 1'b0);
    rchk(`VIM_OFF_FLAGS, 32'h0000_0000, 2'b00);
    for (int b = 5; b < 15; b += 2) one_bit(b, 1'b1);
    pulse(15, 1'b0);
    pulse(2, 1'b0);
    n = taken;
    wchk(`VIM_OFF_ENABLES, 32'h0000_8004, 2'b00);
    ack_en <= 1'b1;
    wait_take(n + 1);
    chk(48'(last_slot), 48'h0000_0000_0002);
    wait_take(n + 2);
    chk(48'(last_slot), 48'h0000_0000_000F);
    ack_en <= 1'b0;
    wchk(`VIM_OFF_ENABLES, 32'h0000_0000, 2'b00);
    foreach (TRAPS[i]) begin
      wchk(`VIM_OFF_SWTRAP, 32'h1 << TRAPS[i], 2'b00);
      expect_req(TRAPS[i]);
    end
    for (int b = 0; b < 3; b++) begin
      pulse(b, 1'b1);
      expect_req(b < 2 ? 18 : 26);
    end
    pulse(0, 1'b0);
    expect_req(0);
    end_of_test();
  end
endmodule
